//--- dv/sttsub_asserts.sv
`default_nettype none
module sttsub_asserts (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq,
  input wire logic        push_valid,
  input wire logic        push_long,
  input wire logic [31:0] push_addr,
  input wire logic [31:0] push_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  // a frozen block answers nothing, so its timing is not judged then
  default disable iff (!resetn || !ce);
  // ****
  // exception stacking steps
  // ****
  sequence fv_s;
    push_valid && !push_long && push_data[15:12] == 4'h0;
  endsequence
  sequence pc_s;
    push_valid && push_long && push_addr == $past(push_addr) - 32'h4;
  endsequence
  sequence sw_s;
    push_valid && !push_long && push_addr == $past(push_addr) - 32'h2;
  endsequence
  stack_order_a: assert property (
    $rose(push_valid) |-> fv_s ##1 pc_s ##1 sw_s ##1 !push_valid)
    else $error("trap stacking out of order");
  // a push burst can only come from a control write two edges earlier
  trap_launch_a: assert property (
    $rose(push_valid) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 8'h00, 2))
    else $error("stacking without a launch");
  // ****
  // register bus
  // ****
  ack_answer_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i > 8'h28 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($rose(resetn) |-> !wb_ack_o && !push_valid && !irq)
    else $error("outputs active at reset release");
  // interrupt level only moves with a register write or a trap push
  irq_fall_a: assert property ($fell(irq) |-> $past(wb_ack_o && wb_we_i))
    else $error("irq dropped without a write");
  irq_rise_a: assert property (
    $rose(irq) |-> $past(wb_ack_o && wb_we_i) || push_valid)
    else $error("irq raised without cause");
endmodule
bind sttsub_core sttsub_asserts chk_i (.clock(clock), .resetn(resetn), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .push_valid(push_valid),
  .push_long(push_long), .push_addr(push_addr), .push_data(push_data));
`default_nettype wire

//--- dv/tb_top.sv
`include "sttsub_consts.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  wire  [31:0] rdat;
  wire         ack;
  wire         irq;
  wire         pv;
  wire         pl;
  wire  [31:0] pa;
  wire  [31:0] pd;
  int          num_errors = 0;
  int          checks = 0;
  logic [64:0] pushes[$];
  logic [31:0] q;
  sttsub_core uut (.clock(clock), .resetn(resetn), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .push_valid(pv), .push_long(pl),
    .push_addr(pa), .push_data(pd));
  always #5 clock = ~clock;
  // short pushes carry only the low half, so the rest is masked off
  always @(posedge clock) begin
    if (pv === 1'b1) begin
      pushes.push_back({pl, pa, pl ? pd : {16'h0, pd[15:0]}});
    end
  end
  task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; the request is held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) num_errors++;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk({33'h0, q}, {33'h0, e});
  endtask
  task automatic ctl(input logic [3:0] op, input logic [1:0] sz, input logic [3:0] cc);
    bus(1'b1, 8'h00, {20'h0, cc, 2'b00, sz, op});
  endtask
  task automatic irq_is(input logic e);
    @(posedge clock);
    chk({64'h0, irq}, {64'h0, e});
  endtask
  task automatic row(input logic [3:0] op, input logic [1:0] sz, input logic [7:0] ra,
                     input logic [31:0] a, b, c, e, input logic [15:0] s);
    bus(1'b1, 8'h04, a);
    bus(1'b1, 8'h08, b);
    bus(1'b1, 8'h0c, c);
    ctl(op, sz, 4'h0);
    rd_chk(ra, e);
    rd_chk(8'h18, {16'h0, s});
  endtask
  // stack pointer 1000 and counter 400 are preset before each launch
  task automatic trap(input logic [3:0] op, input logic [3:0] cc, input logic tk,
                      input logic [15:0] vp, input logic [15:0] sw);
    pushes.delete();
    bus(1'b1, 8'h14, 32'h1000);
    bus(1'b1, 8'h1c, 32'h400);
    ctl(op, 2'h0, cc);
    repeat (5) @(posedge clock);
    chk(65'(pushes.size()), tk ? 65'h3 : 65'h0);
    if (tk) begin
      chk(pushes[0], {1'b0, 32'hffe, 16'h0, vp});
      chk(pushes[1], {1'b1, 32'hffa, 32'h400});
      chk(pushes[2], {1'b0, 32'hff8, 16'h0, sw});
    end
    rd_chk(8'h1c, tk ? {16'h0, vp} : 32'h400);
    rd_chk(8'h14, tk ? 32'hff8 : 32'h1000);
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk(8'h18, 32'h2700);
    rd_chk(8'h24, 32'h0);
    rd_chk(8'h28, 32'h0);
    bus(1'b1, 8'h3c, 32'hffffffff);
    rd_chk(8'h3c, 32'h0);
    $display("test reset done");
    row(`STT_OP_SUBTRACT_IMMEDIATE, 2'h0, 8'h10, 32'h10, 32'h20, 32'h0, 32'hf0, 16'h2719);
    row(`STT_OP_SUBTRACT_WITH_EXTEND, 2'h2, 8'h10, 32'h5, 32'h2, 32'h0, 32'h2, 16'h2700);
    row(`STT_OP_SUBTRACT_QUICK, 2'h2, 8'h10, 32'h20, 32'h0, 32'h0, 32'h18, 16'h2700);
    row(`STT_OP_SUBTRACT_FROM_ADDRESS_REG, 2'h1, 8'h10, 32'h0, 32'h1, 32'h0, 32'hffffffff, 16'h2700);
    row(`STT_OP_SWAP, 2'h2, 8'h10, 32'h12348765, 32'h0, 32'h0, 32'h87651234, 16'h2708);
    row(`STT_OP_TBL, 2'h2, 8'h10, 32'h80, 32'h10, 32'h20, 32'h1800, 16'h2700);
    row(`STT_OP_TBLN, 2'h2, 8'h10, 32'h80, 32'h10, 32'h20, 32'h18, 16'h2700);
    row(`STT_OP_FRAME_RELEASE, 2'h2, 8'h04, 32'h2000, 32'h0, 32'h5a5a, 32'h5a5a, 16'h2700);
    rd_chk(8'h14, 32'h2004);
    row(`STT_OP_TST, 2'h0, 8'h04, 32'h80, 32'h0, 32'h0, 32'h80, 16'h2708);
    row(`STT_OP_TST, 2'h0, 8'h04, 32'h100, 32'h0, 32'h0, 32'h100, 16'h2704);
    // signed byte entries: second entry below the first
    bus(1'b1, 8'h04, 32'h80);
    bus(1'b1, 8'h08, 32'h10);
    bus(1'b1, 8'h0c, 32'he0);
    bus(1'b1, 8'h00, {25'h0, 1'b1, 2'h0, `STT_OP_TBL});
    rd_chk(8'h10, 32'hfffff800);
    rd_chk(8'h18, 32'h2708);
    $display("test arithmetic done");
    bus(1'b1, 8'h20, 32'h20);
    bus(1'b1, 8'h18, 32'h2700);
    trap(`STT_OP_TRAP, 4'h0, 1'b1, 16'h80, 16'h2700);
    trap(`STT_OP_TRV, 4'h0, 1'b0, 16'h1c, 16'h2700);
    bus(1'b1, 8'h18, 32'h2702);
    trap(`STT_OP_TRV, 4'h0, 1'b1, 16'h1c, 16'h2702);
    trap(`STT_OP_TRCC, 4'h1, 1'b0, 16'h1c, 16'h2702);
    trap(`STT_OP_TRCC, 4'h0, 1'b1, 16'h1c, 16'h2702);
    $display("test trap done");
    bus(1'b1, 8'h24, 32'h7);
    bus(1'b1, 8'h28, 32'h1);
    ctl(`STT_OP_SWAP, 2'h2, 4'h0);
    irq_is(1'b1);
    bus(1'b1, 8'h28, 32'h0);
    irq_is(1'b0);
    bus(1'b1, 8'h28, 32'h1);
    irq_is(1'b1);
    bus(1'b1, 8'h24, 32'h1);
    irq_is(1'b0);
    rd_chk(8'h24, 32'h0);
    $display("test interrupt done");
    bus(1'b1, 8'h28, 32'h4);
    bus(1'b1, 8'h18, 32'h0);
    rd_chk(8'h18, 32'h0);
    bus(1'b1, 8'h18, 32'h2705);
    rd_chk(8'h18, 32'h5);
    irq_is(1'b1);
    rd_chk(8'h24, 32'h4);
    trap(`STT_OP_TRAP, 4'h0, 1'b1, 16'h80, 16'h0005);
    rd_chk(8'h18, 32'h2005);
    $display("test privilege done");
    // frozen clock enable: no ack until it returns, then the write lands
    ce <= 1'b0;
    fork
      bus(1'b1, 8'h04, 32'h77);
      begin
        repeat (4) begin
          @(posedge clock);
          chk({64'h0, ack}, 65'h0);
        end
        ce <= 1'b1;
      end
    join
    rd_chk(8'h04, 32'h77);
    // single byte lane write merges into the old word
    sel <= 4'h2;
    bus(1'b1, 8'h04, 32'hffffffff);
    sel <= 4'hf;
    rd_chk(8'h04, 32'h0000ff77);
    $display("test enable done");
    complete_run;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    complete_run;
  end
endmodule
`default_nettype wire

//--- hw/sttsub_consts.vh
`ifndef STTSUB_CONSTS_VH
`define STTSUB_CONSTS_VH
// register byte addresses
`define STT_A_CTRL  8'h00
`define STT_A_OPA   8'h04
`define STT_A_OPB   8'h08
`define STT_A_OPC   8'h0c
`define STT_A_RES   8'h10
`define STT_A_SP    8'h14
`define STT_A_SW    8'h18
`define STT_A_PC    8'h1c
`define STT_A_VEC   8'h20
`define STT_A_IST   8'h24
`define STT_A_IMSK  8'h28
// control word fields
`define STT_OP      3:0
`define STT_SZ      5:4
`define STT_SGN     6
`define STT_CC      11:8
`define STT_BUSY    31
// operation codes
`define STT_OP_SUBTRACT_FROM_ADDRESS_REG 4'h0
`define STT_OP_SUBTRACT_IMMEDIATE 4'h1
`define STT_OP_SUBTRACT_QUICK 4'h2
`define STT_OP_SUBTRACT_WITH_EXTEND 4'h3
`define STT_OP_SWAP 4'h4
`define STT_OP_TBL  4'h5
`define STT_OP_TBLN 4'h6
`define STT_OP_TRAP 4'h7
`define STT_OP_TRCC 4'h8
`define STT_OP_TRV  4'h9
`define STT_OP_TST  4'ha
`define STT_OP_FRAME_RELEASE 4'hb
// operand sizes
`define STT_SZ_B    2'h0
`define STT_SZ_W    2'h1
// status word layout
`define STT_SW_T    15
`define STT_SW_S    13
`define STT_CC_X    4
`define STT_CC_N    3
`define STT_CC_Z    2
`define STT_CC_V    1
`define STT_CC_C    0
`define STT_SW_MASK 16'ha71f
`define STT_CC_MASK 16'h001f
`define STT_SW_RST  16'h2700
// exception stacking
`define STT_VEC_OVF 8'h07
`define STT_FMT     4'h0
`define STT_DEC_W   32'h00000002
`define STT_DEC_L   32'h00000004
`define STT_FRAME_RELEASE_INC 32'h00000004
`define STT_TBL_SH  8
// interrupt status bits
`define STT_EV_DONE 0
`define STT_EV_TRAP 1
`define STT_EV_PRIV 2
`define STT_EV_N    3
`endif

//--- hw/sttsub_core.v
// Notes on behaviour
// - condition codes reflect the previous operation for later conditional use
// - at user level only the condition-code byte of the status word is writable
// - at supervisor level the full status word is readable, but writes keep only the STT_SW_MASK bits
// - address subtract: source from address reg, word or long only
// - immediate and quick subtract into destination, byte word or long
// - extended subtract: destination minus source minus extend flag
// - table interpolate: first entry times 256 plus difference times low byte
// - unscaled table: difference times low byte over 256 plus first entry
// - trap stacks format/vector, then counter and status, loads vector address
// - conditional trap is taken only when its condition is true
// - overflow trap taken only when V is set, else continue
// - compare with zero only updates condition codes, operand unchanged
// - frame release: reg to stack pointer, pop reg, stack pointer plus 4
// - three-bit interrupt priority mask in supervisor part of status word
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`include "sttsub_consts.vh"
`default_nettype none
module sttsub_core (
  input  wire        clock,
  input  wire        resetn,
  input  wire        ce,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  output wire        irq,
  output wire        push_valid,
  output wire        push_long,
  output wire [31:0] push_addr,
  output wire [31:0] push_data
);
  // ****************************************
  // reset release
  // ****************************************
  reg rs1_ff;
  reg rs2_ff;
  wire rstn = rs2_ff;
  // async assert, release through two flops
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function [31:0] szmask;
    input [1:0] s;
    begin
      case (s)
        `STT_SZ_B: szmask = 32'h000000ff;
        `STT_SZ_W: szmask = 32'h0000ffff;
        default:   szmask = 32'hffffffff;
      endcase
    end
  endfunction

  // sign bit at the operand size
  function topbit;
    input [32:0] v;
    input [1:0]  s;
    begin
      case (s)
        `STT_SZ_B: topbit = v[7];
        `STT_SZ_W: topbit = v[15];
        default:   topbit = v[31];
      endcase
    end
  endfunction

  // borrow out of the operand size
  function borrow;
    input [32:0] v;
    input [1:0]  s;
    begin
      case (s)
        `STT_SZ_B: borrow = v[8];
        `STT_SZ_W: borrow = v[16];
        default:   borrow = v[32];
      endcase
    end
  endfunction

  // table entry widened to 32 bits
  function [31:0] widen;
    input [31:0] v;
    input [1:0]  s;
    input        sg;
    begin
      case (s)
        `STT_SZ_B: widen = {{24{sg & v[7]}}, v[7:0]};
        `STT_SZ_W: widen = {{16{sg & v[15]}}, v[15:0]};
        default:   widen = v;
      endcase
    end
  endfunction

  // condition test against the code byte
  function cond_true;
    input [3:0] c;
    input [4:0] f;
    reg n, z, v, k;
    begin
      n = f[`STT_CC_N];
      z = f[`STT_CC_Z];
      v = f[`STT_CC_V];
      k = f[`STT_CC_C];
      case (c)
        4'h0: cond_true = 1'b1;
        4'h1: cond_true = 1'b0;
        4'h2: cond_true = ~k & ~z;
        4'h3: cond_true = k | z;
        4'h4: cond_true = ~k;
        4'h5: cond_true = k;
        4'h6: cond_true = ~z;
        4'h7: cond_true = z;
        4'h8: cond_true = ~v;
        4'h9: cond_true = v;
        4'ha: cond_true = ~n;
        4'hb: cond_true = n;
        4'hc: cond_true = n == v;
        4'hd: cond_true = n != v;
        4'he: cond_true = ~z & (n == v);
        default: cond_true = z | (n != v);
      endcase
    end
  endfunction

  // byte-lane merge of a bus write
  function [31:0] lanes;
    input [31:0] o;
    input [31:0] d;
    input [3:0]  sel;
    integer i;
    begin
      lanes = o;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) lanes[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  localparam ST_IDLE = 4'h1;
  localparam ST_FV   = 4'h2;
  localparam ST_PC   = 4'h4;
  localparam ST_SW   = 4'h8;

  reg [3:0]  st_ff;
  reg [11:0] ctrl_ff;
  reg [31:0] opa_ff;
  reg [31:0] opb_ff;
  reg [31:0] opc_ff;
  reg [31:0] res_ff;
  reg [31:0] sp_ff;
  reg [15:0] sw_ff;
  reg [31:0] pc_ff;
  reg [7:0]  vec_ff;
  reg [2:0]  ist_ff;
  reg [2:0]  imsk_ff;
  reg        ack_ff;
  reg [31:0] rd_ff;
  reg        pv_ff;
  reg        pl_ff;
  reg [31:0] pa_ff;
  reg [31:0] pd_ff;
  reg [7:0]  tvec_ff;

  wire busy = ~st_ff[0];
  wire req  = wb_cyc_i & wb_stb_i;
  // write lands on the edge where ack is seen
  wire wr   = req & wb_we_i & ack_ff;
  wire sup  = sw_ff[`STT_SW_S];
  wire go   = wr & (wb_adr_i == `STT_A_CTRL) & ~busy;

  // ****************************************
  // datapath on the command about to launch
  // ****************************************
  wire [31:0] cw   = lanes({20'h0, ctrl_ff}, wb_dat_i, wb_sel_i);
  wire [3:0]  op   = cw[`STT_OP];
  wire [1:0]  sz   = cw[`STT_SZ];
  wire [31:0] msk  = szmask(sz);
  wire [4:0]  condition_code_byte  = sw_ff[4:0];
  wire        xin  = condition_code_byte[`STT_CC_X];
  wire        usex = op == `STT_OP_SUBTRACT_WITH_EXTEND;
  wire        useq = op == `STT_OP_SUBTRACT_QUICK;
  // quick data 0 stands for 8
  wire [31:0] qd   = {28'h0, opb_ff[2:0] == 3'h0, opb_ff[2:0]};
  wire [31:0] sa   = opa_ff & msk;
  wire [31:0] sb   = (useq ? qd : opb_ff) & msk;
  wire [32:0] dif  = {1'b0, sa} - {1'b0, sb} - {32'h0, usex & xin};
  wire [31:0] dm   = dif[31:0] & msk;
  wire        dn   = topbit(dif, sz);
  wire        dc   = borrow(dif, sz);
  wire        dv   = (topbit({1'b0, sa}, sz) ^ topbit({1'b0, sb}, sz))
                   & (dn ^ topbit({1'b0, sa}, sz));
  wire [31:0] dres = (opa_ff & ~msk) | dm;
  // address subtract: word source sign-extended, full width result
  wire [31:0] asrc = (sz == `STT_SZ_W) ? {{16{opb_ff[15]}}, opb_ff[15:0]}
                                       : opb_ff;
  wire [31:0] ares = opa_ff - asrc;
  wire [31:0] swp  = {opa_ff[15:0], opa_ff[31:16]};
  // table entries and interpolation
  wire [31:0] ym   = widen(opb_ff, sz, cw[`STT_SGN]);
  wire [31:0] yn   = widen(opc_ff, sz, cw[`STT_SGN]);
  wire [31:0] td   = yn - ym;
  // both factors widened to the product width so no bits are lost
  wire signed [40:0] prod = $signed({{9{td[31]}}, td}) * $signed({33'h0, opa_ff[7:0]});
  wire [31:0] tint = (ym << `STT_TBL_SH) + prod[31:0];
  wire [31:0] tunr = ym + prod[`STT_TBL_SH +: 32];
  wire        ctrue = cond_true(cw[`STT_CC], condition_code_byte);
  wire        tst_z = (opa_ff & msk) == 32'h0;
  wire        tst_n = topbit({1'b0, opa_ff}, sz);

  // ****************************************
  // bus reads
  // ****************************************
  reg [31:0] rmux;
  always @* begin
    case (wb_adr_i)
      `STT_A_CTRL: rmux = {busy, 19'h0, ctrl_ff};
      `STT_A_OPA:  rmux = opa_ff;
      `STT_A_OPB:  rmux = opb_ff;
      `STT_A_OPC:  rmux = opc_ff;
      `STT_A_RES:  rmux = res_ff;
      `STT_A_SP:   rmux = sp_ff;
      // user level sees only the code byte
      `STT_A_SW:   rmux = {16'h0, sup ? sw_ff : {8'h0, sw_ff[7:0]}};
      `STT_A_PC:   rmux = pc_ff;
      `STT_A_VEC:  rmux = {24'h0, vec_ff};
      `STT_A_IST:  rmux = {29'h0, ist_ff};
      `STT_A_IMSK: rmux = {29'h0, imsk_ff};
      default:     rmux = 32'h0;
    endcase
  end

  // ****************************************
  // status word write request
  // ****************************************
  wire        sw_wr  = wr & (wb_adr_i == `STT_A_SW);
  wire [31:0] sw_lane = lanes({16'h0, sw_ff}, wb_dat_i, wb_sel_i);
  wire [15:0] sw_new  = sw_lane[15:0];
  // changing the upper byte at user level is refused and flagged
  wire        priv   = sw_wr & ~sup & wb_sel_i[1]
                     & (wb_dat_i[15:8] != sw_ff[15:8]);

  // ****************************************
  // events
  // ****************************************
  reg [2:0] ev;
  always @* begin
    ev = 3'h0;
    ev[`STT_EV_DONE] = go;
    ev[`STT_EV_TRAP] = st_ff[3];
    ev[`STT_EV_PRIV] = priv;
  end

  // ****************************************
  // main sequential logic
  // ****************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_ff   <= ST_IDLE;
      ctrl_ff <= 12'h000;
      opa_ff  <= 32'h0;
      opb_ff  <= 32'h0;
      opc_ff  <= 32'h0;
      res_ff  <= 32'h0;
      sp_ff   <= 32'h0;
      sw_ff   <= `STT_SW_RST;
      pc_ff   <= 32'h0;
      vec_ff  <= 8'h00;
      tvec_ff <= 8'h00;
      ist_ff  <= 3'h0;
      imsk_ff <= 3'h0;
      ack_ff  <= 1'b0;
      rd_ff   <= 32'h0;
      pv_ff   <= 1'b0;
      pl_ff   <= 1'b0;
      pa_ff   <= 32'h0;
      pd_ff   <= 32'h0;
    end else if (ce) begin
      // one-wait-state slave, ack drops after one cycle
      ack_ff <= req & ~ack_ff;
      rd_ff  <= rmux;
      pv_ff  <= 1'b0;
      // sticky events, a new event beats the clear
      if (wr & (wb_adr_i == `STT_A_IST))
        ist_ff <= (ist_ff & ~wb_dat_i[2:0]) | ev;
      else
        ist_ff <= ist_ff | ev;
      if (wr & (wb_adr_i == `STT_A_IMSK)) imsk_ff <= wb_dat_i[2:0];
      // plain register writes
      if (wr & (wb_adr_i == `STT_A_OPA)) opa_ff <= lanes(opa_ff, wb_dat_i, wb_sel_i);
      if (wr & (wb_adr_i == `STT_A_OPB)) opb_ff <= lanes(opb_ff, wb_dat_i, wb_sel_i);
      if (wr & (wb_adr_i == `STT_A_OPC)) opc_ff <= lanes(opc_ff, wb_dat_i, wb_sel_i);
      if (wr & (wb_adr_i == `STT_A_PC) & ~busy) pc_ff <= lanes(pc_ff, wb_dat_i, wb_sel_i);
      if (wr & (wb_adr_i == `STT_A_SP) & ~busy) sp_ff <= lanes(sp_ff, wb_dat_i, wb_sel_i);
      if (wr & (wb_adr_i == `STT_A_VEC)) vec_ff <= wb_sel_i[0] ? wb_dat_i[7:0] : vec_ff;
      // mask field and control bits only for supervisor
      if (sw_wr & ~busy) begin
        if (sup)
          sw_ff <= sw_new & `STT_SW_MASK;
        else
          sw_ff <= (sw_ff & ~`STT_CC_MASK) | (sw_new & `STT_CC_MASK);
      end
      if (go) begin
        ctrl_ff <= cw[11:0];
        case (op)
          `STT_OP_SUBTRACT_FROM_ADDRESS_REG: begin
            res_ff <= ares;
            opa_ff <= ares;
          end
          `STT_OP_SUBTRACT_IMMEDIATE, `STT_OP_SUBTRACT_QUICK, `STT_OP_SUBTRACT_WITH_EXTEND: begin
            res_ff <= dres;
            opa_ff <= dres;
            sw_ff[`STT_CC_X] <= dc;
            sw_ff[`STT_CC_C] <= dc;
            sw_ff[`STT_CC_N] <= dn;
            sw_ff[`STT_CC_V] <= dv;
            // extended form only clears Z, so chains test as one
            sw_ff[`STT_CC_Z] <= (dm == 32'h0) & (~usex | condition_code_byte[`STT_CC_Z]);
          end
          `STT_OP_SWAP: begin
            res_ff <= swp;
            opa_ff <= swp;
            sw_ff[`STT_CC_N] <= swp[31];
            sw_ff[`STT_CC_Z] <= swp == 32'h0;
            sw_ff[`STT_CC_V] <= 1'b0;
            sw_ff[`STT_CC_C] <= 1'b0;
          end
          `STT_OP_TBL, `STT_OP_TBLN: begin
            res_ff <= (op == `STT_OP_TBL) ? tint : tunr;
            opa_ff <= (op == `STT_OP_TBL) ? tint : tunr;
            sw_ff[`STT_CC_N] <= (op == `STT_OP_TBL) ? tint[31] : tunr[31];
            sw_ff[`STT_CC_Z] <= ((op == `STT_OP_TBL) ? tint : tunr) == 32'h0;
            sw_ff[`STT_CC_V] <= 1'b0;
            sw_ff[`STT_CC_C] <= 1'b0;
          end
          `STT_OP_TST: begin
            // operand left alone, only codes move
            sw_ff[`STT_CC_N] <= tst_n;
            sw_ff[`STT_CC_Z] <= tst_z;
            sw_ff[`STT_CC_V] <= 1'b0;
            sw_ff[`STT_CC_C] <= 1'b0;
          end
          `STT_OP_FRAME_RELEASE: begin
            opa_ff <= opc_ff;
            res_ff <= opc_ff;
            sp_ff  <= opa_ff + `STT_FRAME_RELEASE_INC;
          end
          default: begin
          end
        endcase
        // exception entry, first push is the format/vector word
        if ((op == `STT_OP_TRAP) | ((op == `STT_OP_TRCC) & ctrue)
            | ((op == `STT_OP_TRV) & condition_code_byte[`STT_CC_V])) begin
          tvec_ff <= (op == `STT_OP_TRAP) ? vec_ff : `STT_VEC_OVF;
          st_ff   <= ST_FV;
        end
      end
      // stacking sequence, one push per cycle
      case (st_ff)
        ST_IDLE: begin
        end
        ST_FV: begin
          sp_ff <= sp_ff - `STT_DEC_W;
          pa_ff <= sp_ff - `STT_DEC_W;
          pd_ff <= {16'h0, `STT_FMT, 2'h0, tvec_ff, 2'h0};
          pl_ff <= 1'b0;
          pv_ff <= 1'b1;
          st_ff <= ST_PC;
        end
        ST_PC: begin
          sp_ff <= sp_ff - `STT_DEC_L;
          pa_ff <= sp_ff - `STT_DEC_L;
          pd_ff <= pc_ff;
          pl_ff <= 1'b1;
          pv_ff <= 1'b1;
          st_ff <= ST_SW;
        end
        ST_SW: begin
          sp_ff <= sp_ff - `STT_DEC_W;
          pa_ff <= sp_ff - `STT_DEC_W;
          pd_ff <= {16'h0, sw_ff};
          pl_ff <= 1'b0;
          pv_ff <= 1'b1;
          pc_ff <= {22'h0, tvec_ff, 2'h0};
          sw_ff[`STT_SW_S] <= 1'b1;
          sw_ff[`STT_SW_T] <= 1'b0;
          st_ff <= ST_IDLE;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_ack_o   = ack_ff;
  assign wb_dat_o   = rd_ff;
  assign irq        = |(ist_ff & imsk_ff);
  assign push_valid = pv_ff;
  assign push_long  = pl_ff;
  assign push_addr  = pa_ff;
  assign push_data  = pd_ff;
endmodule
`default_nettype wire
